// *** design/fba_bias_adjust.v ***
// Purpose: raise/lower bias on the frequency reference of a motor drive
// Assumes: AHB-Lite slave, zero wait, word accesses only; one clock
// Notes: bias, limits and references in 0.1 % of maximum output frequency
//
// Notes on behaviour
// - mode select used only with zero step
// - mode 0 holds bias when idle
// - mode 1 clears bias on both/neither
// - after clear, ramp to plain reference
// - stored bias on run, clear on change
// - hold off: add stored bias to reference, except with keypad source
// - hold on: commit bias after 5 s
// - clear bias when function unassigned
// - clear bias on reference source change
// - clear bias on maximum frequency write
// - large reference jump freezes bias
// - freeze only for analog or pulse
// - clamp bias to upper limit
// - clamp bias to lower limit
// - keypad: fold bias into reference
// - zero lower limit blocks negative bias
// - limit select 0: larger of floor/analog
// - limit select 1: floor only
// - up/down active with limit select 0: analog is the limit
// - zero step: ramp bias while held
// - nonzero step: one step per press
//
// The placing of the registers and the AHB-Lite register port were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "fba_consts.vh"

module fba_bias_adjust #(
	parameter COMMIT_CYCLES = `FBA_COMMIT_CYCLES
) (
	// clock and reset
	input  wire        sys_clk,
	input  wire        rst_n,
	// register bus
	input  wire        hsel,
	input  wire [31:0] haddr,
	input  wire [1:0]  htrans,
	input  wire        hwrite,
	input  wire [2:0]  hsize,
	input  wire [31:0] hwdata,
	input  wire        hready,
	output wire        hreadyout,
	output wire        hresp,
	output reg  [31:0] hrdata,
	// digital terminals
	input  wire        raiseIn,
	input  wire        lowerIn,
	input  wire        localRemoteIn,
	input  wire        extRefSelIn,
	// drive control core
	input  wire        runCmd,
	input  wire [11:0] freqRef,
	input  wire [11:0] analogBias,
	input  wire        upDownActive,
	// results
	output reg  [11:0] outRef,
	output reg  [11:0] biasMon,
	output reg  [11:0] lowerRefLimit,
	output reg         biasFrozen
);

	localparam [31:0] COMMIT_LAST = COMMIT_CYCLES - 1;

	// clamp a wide value into the bias window
	function [11:0] clampBias;
		input signed [15:0] v;
		input signed [11:0] hi;
		input signed [11:0] lo;
		begin
			if (v > hi)
				clampBias = hi;
			else if (v < lo)
				clampBias = lo;
			else
				clampBias = v[11:0];
		end
	endfunction

	// pin synchronisers
	reg  [3:0] syncA_ff;
	reg  [3:0] syncB_ff;
	reg  [3:0] prevB_ff;
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			syncA_ff <= 4'h0;
			syncB_ff <= 4'h0;
			prevB_ff <= 4'h0;
		end else begin
			syncA_ff <= {extRefSelIn, localRemoteIn, lowerIn, raiseIn};
			syncB_ff <= syncA_ff;
			prevB_ff <= syncB_ff;
		end
	end
	wire raise      = syncB_ff[0];
	wire lower      = syncB_ff[1];
	wire raiseRise  = syncB_ff[0] & ~prevB_ff[0];
	wire lowerRise  = syncB_ff[1] & ~prevB_ff[1];
	wire srcPinChg  = |(syncB_ff[3:2] ^ prevB_ff[3:2]);

	// bus slave
	reg        aValid_ff;
	reg        aWrite_ff;
	reg  [7:0] aOfs_ff;
	reg  [`FBA_CTRL_W-1:0] ctrl_ff;
	reg  [11:0] step_ff;
	reg  [11:0] fluct_ff;
	reg  [11:0] upper_ff;
	reg  [11:0] lower_ff;
	reg  [11:0] floor_ff;
	reg  [11:0] maxFreq_ff;
	reg  [15:0] ramp0_ff;
	reg  [15:0] ramp1_ff;
	reg  [11:0] stored_ff;
	reg  [11:0] keypad_ff;
	reg  [11:0] liveBias_ff;
	reg  [31:0] rdMux;

	wire addrPhase = hsel & htrans[1] & hready;
	wire wrStb     = aValid_ff & aWrite_ff;
	wire wrStored  = wrStb & (aOfs_ff == `FBA_OFS_STORED);
	wire wrKeypad  = wrStb & (aOfs_ff == `FBA_OFS_KEYPAD);
	wire wrMaxFreq = wrStb & (aOfs_ff == `FBA_OFS_MAXFREQ);

	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;

	always @* begin
		rdMux = 32'h0000_0000;
		case (haddr[7:0])
			`FBA_OFS_CTRL:    rdMux = {25'h0, ctrl_ff};
			`FBA_OFS_STEP:    rdMux = {20'h0, step_ff};
			`FBA_OFS_STORED:  rdMux = {20'h0, stored_ff};
			`FBA_OFS_FLUCT:   rdMux = {20'h0, fluct_ff};
			`FBA_OFS_UPPER:   rdMux = {20'h0, upper_ff};
			`FBA_OFS_LOWER:   rdMux = {20'h0, lower_ff};
			`FBA_OFS_FLOOR:   rdMux = {20'h0, floor_ff};
			`FBA_OFS_MAXFREQ: rdMux = {20'h0, maxFreq_ff};
			`FBA_OFS_RAMP:    rdMux = {ramp1_ff, ramp0_ff};
			`FBA_OFS_BIASMON: rdMux = {20'h0, biasMon};
			`FBA_OFS_OUTREF:  rdMux = {20'h0, outRef};
			`FBA_OFS_STATUS:  rdMux = {29'h0, lower, raise, biasFrozen};
			`FBA_OFS_KEYPAD:  rdMux = {20'h0, keypad_ff};
			default:          rdMux = 32'h0000_0000;
		endcase
	end

	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			aValid_ff  <= 1'b0;
			aWrite_ff  <= 1'b0;
			aOfs_ff    <= 8'h00;
			hrdata     <= 32'h0000_0000;
			ctrl_ff    <= `FBA_CTRL_RST;
			step_ff    <= `FBA_STEP_RST;
			fluct_ff   <= `FBA_FLUCT_RST;
			upper_ff   <= `FBA_UPPER_RST;
			lower_ff   <= `FBA_LOWER_RST;
			floor_ff   <= `FBA_FLOOR_RST;
			maxFreq_ff <= `FBA_MAXFREQ_RST;
			ramp0_ff   <= `FBA_RAMP_RST;
			ramp1_ff   <= `FBA_RAMP_RST;
		end else begin
			aValid_ff <= addrPhase;
			aWrite_ff <= hwrite;
			aOfs_ff   <= haddr[7:0];
			// read data registered at the address phase, valid in the data phase
			if (addrPhase & ~hwrite)
				hrdata <= rdMux;
			if (wrStb) begin
				case (aOfs_ff)
					`FBA_OFS_CTRL:    ctrl_ff    <= hwdata[`FBA_CTRL_W-1:0];
					`FBA_OFS_STEP:    step_ff    <= hwdata[11:0];
					`FBA_OFS_FLUCT:   fluct_ff   <= hwdata[11:0];
					`FBA_OFS_UPPER:   upper_ff   <= hwdata[11:0];
					`FBA_OFS_LOWER:   lower_ff   <= hwdata[11:0];
					`FBA_OFS_FLOOR:   floor_ff   <= hwdata[11:0];
					`FBA_OFS_MAXFREQ: maxFreq_ff <= hwdata[11:0];
					`FBA_OFS_RAMP: begin
						ramp0_ff <= hwdata[15:0];
						ramp1_ff <= hwdata[31:16];
					end
					default: ;
				endcase
			end
		end
	end

	// configuration decode
	wire       holdOn   = ctrl_ff[`FBA_CTRL_HOLD];
	wire       rampSel  = ctrl_ff[`FBA_CTRL_RAMP];
	wire       modeSel  = ctrl_ff[`FBA_CTRL_MODE];
	wire       limSel   = ctrl_ff[`FBA_CTRL_LIMSEL];
	wire       assigned = ctrl_ff[`FBA_CTRL_ASSIGN];
	wire [1:0] srcSel   = ctrl_ff[`FBA_CTRL_SRC_HI:`FBA_CTRL_SRC_LO];
	wire       isKeypad = (srcSel == `FBA_SRC_KEYPAD);
	wire       isAnalog = (srcSel == `FBA_SRC_ANALOG) | (srcSel == `FBA_SRC_PULSE);
	wire       stepZero = (step_ff == 12'h000);
	wire       anyCmd   = raise | lower;
	wire signed [11:0] hiLim = upper_ff;
	wire signed [11:0] loLim = lower_ff;

	// ramp rate divider
	reg  [15:0] rampCnt_ff;
	wire [15:0] rampLen  = rampSel ? ramp1_ff : ramp0_ff;
	wire        rampTick = (rampCnt_ff >= rampLen);
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n)
			rampCnt_ff <= 16'h0000;
		else if (rampTick)
			rampCnt_ff <= 16'h0000;
		else
			rampCnt_ff <= rampCnt_ff + 16'h0001;
	end

	// change detection
	reg  [1:0]  srcPrev_ff;
	reg  [11:0] refPrev_ff;
	reg  [11:0] anchor_ff;
	reg         runPrev_ff;
	wire srcChg  = srcPinChg | (srcSel != srcPrev_ff);
	wire refChg  = ~isKeypad & ~isAnalog & (freqRef != refPrev_ff);
	wire clrAll  = ~assigned | srcChg | wrMaxFreq | refChg;
	wire mode1Clr = stepZero & modeSel & (raise == lower);
	wire runRise = runCmd & ~runPrev_ff;

	reg  [25:0] idleCnt_ff;
	wire        commitStb = runCmd & ~anyCmd & (idleCnt_ff == COMMIT_LAST[25:0]);
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n)
			idleCnt_ff <= 26'h000_0000;
		else if (anyCmd | ~runCmd)
			idleCnt_ff <= 26'h000_0000;
		else if (idleCnt_ff != COMMIT_LAST[25:0] + 26'h1)
			idleCnt_ff <= idleCnt_ff + 26'h1;
	end

	// fluctuation freeze
	wire [11:0] refDiff = (freqRef > anchor_ff) ? (freqRef - anchor_ff) : (anchor_ff - freqRef);
	reg  [11:0] target;
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			biasFrozen <= 1'b0;
			anchor_ff  <= 12'h000;
			srcPrev_ff <= 2'h0;
			refPrev_ff <= 12'h000;
			runPrev_ff <= 1'b0;
		end else begin
			srcPrev_ff <= srcSel;
			refPrev_ff <= freqRef;
			runPrev_ff <= runCmd;
			if (!isAnalog) begin
				biasFrozen <= 1'b0;
				anchor_ff  <= freqRef;
			end else if (anyCmd && refDiff > fluct_ff) begin
				// hold bias while the output chases the new reference
				biasFrozen <= 1'b1;
				anchor_ff  <= freqRef;
			end else if (biasFrozen && outRef == target) begin
				biasFrozen <= 1'b0;
			end else if (!anyCmd) begin
				anchor_ff <= freqRef;
			end
		end
	end

	// bias next state
	reg  [11:0] nxt_live;
	reg  [11:0] nxt_stored;
	reg  [11:0] nxt_keypad;
	wire signed [15:0] liveW   = {{4{liveBias_ff[11]}}, liveBias_ff};
	wire signed [15:0] storedW = {{4{stored_ff[11]}}, stored_ff};
	wire signed [15:0] stepW   = {4'h0, step_ff};
	wire [15:0] keyFold = {4'h0, keypad_ff} + liveW;
	always @* begin
		nxt_live   = liveBias_ff;
		nxt_stored = stored_ff;
		nxt_keypad = keypad_ff;
		if (wrStored)
			nxt_stored = clampBias({{4{hwdata[11]}}, hwdata[11:0]}, hiLim, loLim);
		if (wrKeypad)
			nxt_keypad = hwdata[11:0];
		if (clrAll) begin
			nxt_live   = 12'h000;
			nxt_stored = 12'h000;
		end else if (!runCmd) begin
			// bias dropped with the run command
			nxt_live = 12'h000;
		end else if (runRise && holdOn && !isKeypad) begin
			nxt_live = stored_ff;
		end else if (mode1Clr) begin
			nxt_live   = 12'h000;
			nxt_stored = 12'h000;
		end else if (!stepZero) begin
			if (raiseRise && !lower)
				nxt_live = clampBias(liveW + stepW, hiLim, loLim);
			else if (lowerRise && !raise)
				nxt_live = clampBias(liveW - stepW, hiLim, loLim);
		end else if (!biasFrozen && rampTick) begin
			if (raise && !lower)
				nxt_live = clampBias(liveW + 16'sh0001, hiLim, loLim);
			else if (lower && !raise)
				nxt_live = clampBias(liveW - 16'sh0001, hiLim, loLim);
		end
		if (!clrAll && commitStb && holdOn && liveBias_ff != 12'h000) begin
			if (isKeypad) begin
				// fold bias into the keypad reference
				nxt_keypad = (keyFold[15]) ? 12'h000 : keyFold[11:0];
				nxt_live   = 12'h000;
			end else begin
				nxt_stored = clampBias(liveW, hiLim, loLim);
				nxt_live   = 12'h000;
			end
		end
	end

	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			liveBias_ff <= 12'h000;
			stored_ff   <= 12'h000;
			keypad_ff   <= 12'h000;
		end else begin
			liveBias_ff <= nxt_live;
			stored_ff   <= nxt_stored;
			keypad_ff   <= nxt_keypad;
		end
	end

	// effective bias and lower reference limit
	reg  [11:0] nxt_bias;
	reg  [11:0] nxt_limit;
	always @* begin
		nxt_bias = 12'h000;
		if (runCmd) begin
			if (holdOn || isKeypad)
				nxt_bias = liveBias_ff;
			else
				// stored bias added with hold off
				nxt_bias = clampBias(liveW + storedW, hiLim, loLim);
		end
		if (limSel)
			nxt_limit = floor_ff;
		else if (upDownActive)
			nxt_limit = analogBias;
		else
			nxt_limit = (analogBias > floor_ff) ? analogBias : floor_ff;
	end

	// output reference ramp
	wire [11:0] baseRef = isKeypad ? keypad_ff : freqRef;
	wire signed [15:0] sumRef = {4'h0, baseRef} + {{4{biasMon[11]}}, biasMon};
	always @* begin
		target = 12'h000;
		if (runCmd) begin
			if (sumRef < $signed({4'h0, lowerRefLimit}))
				target = lowerRefLimit;
			else if (sumRef > $signed({4'h0, `FBA_REF_MAX}))
				target = `FBA_REF_MAX;
			else
				target = sumRef[11:0];
		end
	end

	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			biasMon       <= 12'h000;
			lowerRefLimit <= 12'h000;
			outRef        <= 12'h000;
		end else begin
			biasMon       <= nxt_bias;
			lowerRefLimit <= nxt_limit;
			// follow the target at the selected ramp rate
			if (rampTick) begin
				if (outRef < target)
					outRef <= outRef + 12'h001;
				else if (outRef > target)
					outRef <= outRef - 12'h001;
			end
		end
	end

endmodule // fba_bias_adjust

`default_nettype wire

// *** design/fba_consts.vh ***
// Purpose: constants for the frequency bias adjust block
// Assumes: percentages in units of 0.1 % of maximum output frequency
// Notes: offsets are byte addresses on the register bus
`ifndef FBA_CONSTS_VH
`define FBA_CONSTS_VH

// clock and timing
`define FBA_CLK_PERIOD_NS 100
`define FBA_COMMIT_TIME_MS 5000
`define FBA_COMMIT_CYCLES (`FBA_COMMIT_TIME_MS * (1000000 / `FBA_CLK_PERIOD_NS))

// register byte offsets
`define FBA_OFS_CTRL    8'h00
`define FBA_OFS_STEP    8'h04
`define FBA_OFS_STORED  8'h08
`define FBA_OFS_FLUCT   8'h0c
`define FBA_OFS_UPPER   8'h10
`define FBA_OFS_LOWER   8'h14
`define FBA_OFS_FLOOR   8'h18
`define FBA_OFS_MAXFREQ 8'h1c
`define FBA_OFS_RAMP    8'h20
`define FBA_OFS_BIASMON 8'h24
`define FBA_OFS_OUTREF  8'h28
`define FBA_OFS_STATUS  8'h2c
`define FBA_OFS_KEYPAD  8'h30

// control register fields
`define FBA_CTRL_HOLD   0
`define FBA_CTRL_RAMP   1
`define FBA_CTRL_MODE   2
`define FBA_CTRL_LIMSEL 3
`define FBA_CTRL_ASSIGN 4
`define FBA_CTRL_SRC_LO 5
`define FBA_CTRL_SRC_HI 6
`define FBA_CTRL_W      7

// reference source codes
`define FBA_SRC_KEYPAD 2'h0
`define FBA_SRC_ANALOG 2'h1
`define FBA_SRC_PULSE  2'h2
`define FBA_SRC_DIGITAL 2'h3

// reset values and output reference ceiling
`define FBA_CTRL_RST    7'h10
`define FBA_STEP_RST    12'h000
`define FBA_FLUCT_RST   12'h00a
`define FBA_UPPER_RST   12'h3e8
`define FBA_LOWER_RST   12'h000
`define FBA_FLOOR_RST   12'h000
`define FBA_MAXFREQ_RST 12'h3e8
`define FBA_RAMP_RST    16'h03e8
`define FBA_REF_MAX     12'h44c

`endif

// *** verif/fba_bias_monitor.sv ***
// Purpose: port checker for the frequency bias adjust block
// Assumes: bound to fba_bias_adjust, one clock
// Notes: sees ports only; mode-dependent behaviour is left to the bench
`timescale 1ns/10ps
`default_nettype none
module fba_bias_monitor (
	// clock and reset
	input wire logic        sys_clk,
	input wire logic        rst_n,
	// register bus
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic        hready,
	input wire logic        hreadyout,
	input wire logic        hresp,
	input wire logic [31:0] hrdata,
	// terminals and results
	input wire logic        localRemoteIn,
	input wire logic        extRefSelIn,
	input wire logic        runCmd,
	input wire logic [11:0] outRef,
	input wire logic [11:0] biasMon
);
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rst_n);
	sequence busReq(logic [31:0] a, logic w);
		hsel && htrans[1] && hready && haddr == a && hwrite == w;
	endsequence
	sequence stopped3;
		!runCmd [*3];
	endsequence
	a_bus_okay: assert property (hreadyout && !hresp) else $error("bus not okay");
	a_unmapped_zero: assert property (busReq(32'h40, 1'b0) |=> hrdata == 32'h0)
		else $error("unmapped read not zero");
	a_stop_bias: assert property (stopped3 |-> biasMon == 12'h0)
		else $error("bias kept while stopped");
	// once stopped the output ramps down toward zero, it never climbs
	a_stop_out: assert property (stopped3 |-> outRef <= $past(outRef))
		else $error("output rose while stopped");
	a_source_clear: assert property ($changed(localRemoteIn) || $changed(extRefSelIn)
		|-> ##[1:6] biasMon == 12'h0) else $error("bias kept after source change");
	a_maxfreq_clear: assert property (busReq(32'h1c, 1'b1) |-> ##[1:6] biasMon == 12'h0)
		else $error("bias kept after max frequency write");
	a_bias_upper: assert property ($signed(biasMon) <= 1000) else $error("bias too high");
	a_bias_lower: assert property ($signed(biasMon) >= -999) else $error("bias too low");
	a_out_ceiling: assert property (outRef <= 12'd1100) else $error("output over ceiling");
endmodule // fba_bias_monitor
bind fba_bias_adjust fba_bias_monitor u_fba_bias_monitor (.sys_clk(sys_clk), .rst_n(rst_n),
	.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready),
	.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .localRemoteIn(localRemoteIn),
	.extRefSelIn(extRefSelIn), .runCmd(runCmd), .outRef(outRef), .biasMon(biasMon));
`default_nettype wire

// *** verif/fba_term_model.sv ***
// Purpose: raise/lower terminal contacts for the bias adjust bench
// Assumes: contacts driven push-pull, no bounce
// Notes: a press holds the pins, then a release gap follows
`timescale 1ns/10ps
`default_nettype none
module fba_term_model (
	// clock and reset
	input  wire logic       sys_clk,
	input  wire logic       rst_n,
	// request from the bench
	input  wire logic       go,
	input  wire logic [1:0] cmd,
	input  wire logic [7:0] holdLen,
	// terminal pins and busy flag
	output var logic        raiseIn,
	output var logic        lowerIn,
	output var logic        busy
);
	logic [8:0] cnt_ff;
	// the gap lets the edge detector see each press as a new one
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_ff <= 9'h0;
			raiseIn <= 1'b0;
			lowerIn <= 1'b0;
			busy <= 1'b0;
		end else if (go && !busy) begin
			cnt_ff <= {1'b0, holdLen} + 9'h8;
			raiseIn <= cmd[0];
			lowerIn <= cmd[1];
			busy <= 1'b1;
		end else if (busy) begin
			cnt_ff <= cnt_ff - 9'h1;
			if (cnt_ff == 9'h9) begin
				raiseIn <= 1'b0;
				lowerIn <= 1'b0;
			end
			if (cnt_ff == 9'h1)
				busy <= 1'b0;
		end
	end
endmodule // fba_term_model
`default_nettype wire

// *** verif/tb_top.sv ***
// Purpose: self-checking bench for the frequency bias adjust block
// Assumes: commit interval shortened to 200 cycles
// Notes: register reads are checked against a queue of expected values
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	logic        sys_clk, rst_n, hsel, hwrite, go, rdPend, runCmd, upDownActive;
	logic        hreadyout, hresp, busy, raiseIn, lowerIn, localRemoteIn, extRefSelIn;
	logic        biasFrozen;
	logic [1:0]  htrans, cmd;
	logic [2:0]  hsize;
	logic [7:0]  holdLen;
	logic [11:0] freqRef, analogBias, outRef, biasMon, lowerRefLimit, step, ab;
	logic [31:0] haddr, hwdata, hrdata;
	logic [11:0] expQ[$];
	string       nmQ[$];
	int          seed, tmp, nFail, checkCount, k;
	logic [19:0] rstTab [8] = '{20'h00010, 20'h0c00a, 20'h103e8, 20'h14000, 20'h1c3e8,
		20'h04000, 20'h40000, 20'h24000};
	wire         hready;
	assign hready = hreadyout;
	fba_bias_adjust #(.COMMIT_CYCLES(200)) u_fba_bias_adjust (.sys_clk(sys_clk), .rst_n(rst_n),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.raiseIn(raiseIn), .lowerIn(lowerIn), .localRemoteIn(localRemoteIn),
		.extRefSelIn(extRefSelIn), .runCmd(runCmd), .freqRef(freqRef), .analogBias(analogBias),
		.upDownActive(upDownActive), .outRef(outRef), .biasMon(biasMon),
		.lowerRefLimit(lowerRefLimit), .biasFrozen(biasFrozen));
	fba_term_model u_fba_term_model (.sys_clk(sys_clk), .rst_n(rst_n), .go(go), .cmd(cmd),
		.holdLen(holdLen), .raiseIn(raiseIn), .lowerIn(lowerIn), .busy(busy));
	always #50 sys_clk = ~sys_clk;
	task automatic chk(input string nm, input logic [11:0] seen, input logic [11:0] exp);
		checkCount++;
		if (seen !== exp) begin
			nFail++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", checkCount, nFail);
		if (nFail == 0 && checkCount > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// address phase held until hready, then data phase held until hready
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [11:0] e);
		@(posedge sys_clk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= w;
		@(posedge sys_clk);
		while (hready !== 1'b1) @(posedge sys_clk);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		if (!w) begin
			expQ.push_back(e);
			nmQ.push_back($sformatf("reg%h", a));
		end
		rdPend <= !w;
		@(posedge sys_clk);
		while (hready !== 1'b1) @(posedge sys_clk);
		rdPend <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d, 12'h0);
	endtask
	task automatic rd(input logic [7:0] a, input logic [11:0] e);
		bus(1'b0, a, 32'h0, e);
	endtask
	task automatic press(input logic [1:0] c, input logic [7:0] n);
		cmd <= c;
		holdLen <= n;
		go <= 1'b1;
		@(posedge sys_clk);
		go <= 1'b0;
		@(posedge sys_clk);
		while (busy) @(posedge sys_clk);
		repeat (4) @(posedge sys_clk);
	endtask
	always @(posedge sys_clk) begin
		if (rdPend && hready === 1'b1)
			chk(nmQ.pop_front(), hrdata[11:0], expQ.pop_front());
	end
	initial begin
		#2000000;
		nFail++;
		report_and_stop;
	end
	initial begin
		sys_clk = 1'b0;
		rst_n = 1'b0;
		{hsel, hwrite, go, rdPend, localRemoteIn, extRefSelIn, runCmd, upDownActive} = 8'h0;
		{htrans, cmd, hsize, holdLen} = 15'h201;
		{freqRef, analogBias, haddr, hwdata} = 88'h0;
		seed = 32'h733f6b11;
		tmp = $random(seed);
		step = 12'h5 + {5'h0, tmp[6:0]};
		ab = 12'h65 + {4'h0, tmp[15:8]};
		repeat (3) @(posedge sys_clk);
		rst_n <= 1'b1;
		// a read-only write is dropped, unmapped reads zero
		wr(8'h24, 32'h123);
		foreach (rstTab[i]) rd(rstTab[i][19:12], rstTab[i][11:0]);
		freqRef <= {2'h0, tmp[25:16]};
		runCmd <= 1'b1;
		wr(8'h20, 32'h00010001);
		wr(8'h04, {20'h0, step});
		wr(8'h00, 32'h70);
		repeat (2) press(2'b01, 8'h3);
		rd(8'h24, step * 12'h2);
		wr(8'h08, {20'h0, step});
		rd(8'h24, step * 12'h3);
		wr(8'h08, 32'h0);
		repeat (3) press(2'b10, 8'h3);
		rd(8'h24, 12'h0);
		wr(8'h14, 32'hfec);
		repeat (5) press(2'b10, 8'h3);
		rd(8'h24, 12'hfec);
		wr(8'h1c, 32'h3e8);
		rd(8'h24, 12'h0);
		for (k = 0; k < 4; k++) begin
			press(2'b01, 8'h3);
			rd(8'h24, step);
			case (k)
				0: localRemoteIn <= ~localRemoteIn;
				1: extRefSelIn <= ~extRefSelIn;
				2: runCmd <= 1'b0;
				default: wr(8'h00, 32'h60);
			endcase
			repeat (8) @(posedge sys_clk);
			rd(8'h24, 12'h0);
			runCmd <= 1'b1;
			wr(8'h00, 32'h70);
		end
		wr(8'h10, {20'h0, step + 12'h3});
		repeat (3) press(2'b01, 8'h3);
		rd(8'h24, step + 12'h3);
		wr(8'h1c, 32'h3e8);
		wr(8'h04, 32'h0);
		wr(8'h10, 32'ha);
		press(2'b01, 8'h40);
		rd(8'h24, 12'ha);
		wr(8'h10, 32'h3e8);
		wr(8'h00, 32'h74);
		press(2'b01, 8'h40);
		rd(8'h24, 12'h0);
		// only the second ramp (ramp1_ff) is fast enough to settle inside the wait
		wr(8'h20, 32'h0001ffff);
		wr(8'h00, 32'h76);
		repeat (2300) @(posedge sys_clk);
		rd(8'h28, freqRef);
		wr(8'h20, 32'h00010001);
		wr(8'h04, {20'h0, step});
		press(2'b01, 8'h3);
		rd(8'h24, step);
		// second press lands inside the idle interval and restarts it
		wr(8'h1c, 32'h3e8);
		wr(8'h00, 32'h71);
		repeat (2) begin
			press(2'b01, 8'h3);
			repeat (150) @(posedge sys_clk);
		end
		rd(8'h08, 12'h0);
		repeat (100) @(posedge sys_clk);
		rd(8'h08, step * 12'h2);
		rd(8'h24, 12'h0);
		wr(8'h30, 32'h12c);
		wr(8'h00, 32'h11);
		press(2'b01, 8'h3);
		repeat (260) @(posedge sys_clk);
		rd(8'h30, 12'h12c + step);
		rd(8'h24, 12'h0);
		wr(8'h04, 32'h0);
		// ramp every cycle so the output settles and any freeze ends inside the wait
		wr(8'h20, 32'h0);
		for (k = 0; k < 3; k++) begin
			wr(8'h00, k == 2 ? 32'h70 : (k ? 32'h50 : 32'h30));
			repeat (1200) @(posedge sys_clk);
			fork
				press(2'b01, 8'h80);
				begin
					repeat (20) @(posedge sys_clk);
					chk("frozen", {11'h0, biasFrozen}, 12'h0);
					freqRef <= freqRef ^ 12'h200;
					repeat (4) @(posedge sys_clk);
					chk("frozen", {11'h0, biasFrozen}, {11'h0, k != 2});
				end
			join
		end
		wr(8'h18, 32'h64);
		analogBias <= ab;
		repeat (4) @(posedge sys_clk);
		chk("limit", lowerRefLimit, ab);
		analogBias <= {6'h0, ab[5:0]};
		repeat (4) @(posedge sys_clk);
		chk("limit", lowerRefLimit, 12'h64);
		upDownActive <= 1'b1;
		repeat (4) @(posedge sys_clk);
		chk("limit", lowerRefLimit, {6'h0, ab[5:0]});
		wr(8'h00, 32'h78);
		repeat (4) @(posedge sys_clk);
		chk("limit", lowerRefLimit, 12'h64);
		report_and_stop;
	end
endmodule // tb_top
`default_nettype wire
